//--- pmt_pkg.sv
package pmt_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [7:0] OFS_TIMER_COUNT   = 8'h11;
  localparam logic [7:0] OFS_TIMER_CONTROL = 8'h12;
  localparam logic [7:0] OFS_PERIOD_LIMIT  = 8'h92;
  localparam logic [7:0] OFS_IRQ_STATUS    = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK      = 8'h8C;

  // Reset values
  localparam logic [7:0] RST_TIMER_COUNT   = 8'h00;
  localparam logic [6:0] RST_TIMER_CONTROL = 7'h00;
  localparam logic [7:0] RST_PERIOD_LIMIT  = 8'hFF;

  // Control field positions
  localparam int CTL_PRE_LSB  = 0;
  localparam int CTL_RUN_BIT  = 2;
  localparam int CTL_POST_LSB = 3;

  // Status / mask bit of the period-match flag
  localparam int FLAG_BIT = 1;

  // Fosc/4: one timer input tick every four core clocks
  localparam int OSC_DIV = 4;

  localparam logic [1:0] PRE_DIV1  = 2'h0;
  localparam logic [1:0] PRE_DIV4  = 2'h1;
  localparam logic [3:0] PRE_TC4   = 4'h3;
  localparam logic [3:0] PRE_TC16  = 4'hF;
endpackage

//--- pmt_props.sv
`timescale 1ns/100ps
module pmt_props
  import pmt_pkg::*;
#(parameter int OSC_DIVIDE = OSC_DIV) (
  input wire logic       CORE_CLK,
  input wire logic       RST_B,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic       IRQ,
  input wire logic       SSP_MATCH,
  input wire logic       PWM_MATCH,
  input wire logic [7:0] PWM_COUNT
);
  logic       run_r;
  logic [7:0] lim_r;
  logic       wr1_r;
  logic       wr2_r;
  wire        quiet = !WR && !wr1_r && !wr2_r;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  // Shadow of run bit and period so count checks know the setup
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      run_r <= 1'b0;
      lim_r <= 8'hFF;
      wr1_r <= 1'b0;
      wr2_r <= 1'b0;
    end else begin
      wr1_r <= WR;
      wr2_r <= wr1_r;
      if (WR && ADDR == OFS_TIMER_CONTROL) run_r <= WDATA[CTL_RUN_BIT];
      if (WR && ADDR == OFS_PERIOD_LIMIT) lim_r <= WDATA;
    end
  end
  rd_idle_a: assert property (!RD |=> RDATA == 8'h00) else $error("read data without read");
  match_pair_a: assert property (SSP_MATCH == PWM_MATCH) else $error("match outputs differ");
  match_cause_a: assert property (SSP_MATCH && quiet |-> PWM_COUNT == 8'h00)
    else $error("match while count not zero");
  step_a: assert property ($changed(PWM_COUNT) && quiet |->
    PWM_COUNT == $past(PWM_COUNT) + 8'h01 || PWM_COUNT == 8'h00) else $error("count skipped");
  wrap_a: assert property ($changed(PWM_COUNT) && PWM_COUNT == 8'h00 && quiet |->
    $past(PWM_COUNT) == lim_r) else $error("wrap away from period");
  halt_a: assert property (!run_r && quiet |-> $stable(PWM_COUNT)) else $error("count while halted");
  tick_rate_a: assert property ($changed(PWM_COUNT) && quiet ##1 !WR ##1 !WR |=>
    PWM_COUNT == $past(PWM_COUNT, 3)) else $error("count faster than tick");
  irq_fall_a: assert property ($fell(IRQ) |-> $past(WR)) else $error("irq dropped by itself");
  cover property (SSP_MATCH);
  cover property ($fell(IRQ));
  cover property (RD ##1 RDATA != 8'h00);
endmodule
bind pmt_timer pmt_props #(.OSC_DIVIDE(OSC_DIVIDE)) u_props (.CORE_CLK, .RST_B, .ADDR, .WDATA,
  .WR, .RD, .RDATA, .IRQ, .SSP_MATCH, .PWM_MATCH, .PWM_COUNT);

//--- pmt_timer.sv
`timescale 1ns/100ps
// Functional notes
// - 8-bit timer count, RW, reset to zero
// - 8-bit period limit, RW, reset all ones
// - Count to period limit, then wrap zero
// - Fosc/4 through prescaler 1, 4, 16
// - Postscale field n divides matches by n+1
// - Postscaler expiry sets flag bit 1
// - Count or control write clears scalers
// - Control write leaves timer count alone
// - Control bit 2 runs or halts timer
// - Match pulse supplied to serial port
// - Count and match supplied to PWM unit
module pmt_timer
  import pmt_pkg::*;
#(
  parameter int OSC_DIVIDE = OSC_DIV
) (
  input  wire logic              CORE_CLK,
  input  wire logic              RST_B,
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [DATA_W-1:0] WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic      [DATA_W-1:0] RDATA,
  output logic                   IRQ,
  output logic                   SSP_MATCH,
  output logic                   PWM_MATCH,
  output logic      [7:0]        PWM_COUNT
);

  // Registers and their next values
  logic [7:0] timer_count_r;
  logic [7:0] timer_count_nxt;
  logic [6:0] timer_control_r;
  logic [7:0] period_limit_r;
  logic [1:0] osc_div_r;
  logic [3:0] pre_cnt_r;
  logic [3:0] post_cnt_r;
  logic       flag_r;
  logic       mask_r;
  logic       match_r;
  logic [1:0] osc_div_nxt;
  logic [3:0] pre_cnt_nxt;
  logic [3:0] post_cnt_nxt;
  logic [6:0] timer_control_nxt;
  logic [7:0] period_limit_nxt;
  logic       flag_nxt;
  logic       mask_nxt;
  logic       match_nxt;
  logic [7:0] rdata_nxt;

  // Decoded strobes, control fields and ticks
  logic       wr_count;
  logic       wr_control;
  logic       wr_period;
  logic       wr_status;
  logic       wr_mask;
  logic       timer_run;
  logic [1:0] prescale_select;
  logic [3:0] postscale_select;
  logic       osc_tick;
  logic       pre_tick;
  logic       match;
  logic       post_tick;
  logic [3:0] pre_tc;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  function automatic logic [7:0] flag_bits(input logic bit_val);
    logic [7:0] v;
    v = 8'h00;
    v[FLAG_BIT] = bit_val;
    return v;
  endfunction

  // Register write decode
  always_comb begin
    wr_count   = 1'b0;
    wr_control = 1'b0;
    wr_period  = 1'b0;
    wr_status  = 1'b0;
    wr_mask    = 1'b0;
    if (WR) begin
      wr_count   = hit(ADDR, OFS_TIMER_COUNT);
      wr_control = hit(ADDR, OFS_TIMER_CONTROL);
      wr_period  = hit(ADDR, OFS_PERIOD_LIMIT);
      wr_status  = hit(ADDR, OFS_IRQ_STATUS);
      wr_mask    = hit(ADDR, OFS_IRQ_MASK);
    end
  end

  // Control fields
  always_comb begin
    timer_run        = timer_control_r[CTL_RUN_BIT];
    prescale_select  = timer_control_r[CTL_PRE_LSB +: 2];
    postscale_select = timer_control_r[CTL_POST_LSB +: 4];
  end

  // Instruction clock: one tick per OSC_DIVIDE core clocks, for OSC_DIVIDE of 1 to 4
  always_comb begin
    osc_tick = 1'b0;
    if (osc_div_r == 2'((OSC_DIVIDE - 1) & 3)) begin
      osc_tick = 1'b1;
    end
  end

  // Prescaler terminal count
  always_comb begin
    unique case (prescale_select)
      PRE_DIV1: begin
        pre_tc = 4'h0;
      end
      PRE_DIV4: begin
        pre_tc = PRE_TC4;
      end
      default: begin
        pre_tc = PRE_TC16;
      end
    endcase
  end

  // Tick chain: prescaler, period match, postscaler expiry
  always_comb begin
    pre_tick  = 1'b0;
    match     = 1'b0;
    post_tick = 1'b0;
    if (timer_run && osc_tick) begin
      pre_tick = (pre_cnt_r >= pre_tc);
    end
    if (pre_tick) begin
      match = (timer_count_r == period_limit_r);
    end
    if (match) begin
      post_tick = (post_cnt_r >= postscale_select);
    end
  end

  // Instruction clock divider, free running from reset
  always_comb begin
    osc_div_nxt = osc_div_r + 2'h1;
    if (osc_tick) begin
      osc_div_nxt = 2'h0;
    end
  end

  // Writes never realign the divider
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      osc_div_r <= 2'h0;
    end else begin
      osc_div_r <= osc_div_nxt;
    end
  end

  // Prescaler restarts on count and control writes
  always_comb begin
    pre_cnt_nxt = pre_cnt_r;
    if (wr_count || wr_control) begin
      pre_cnt_nxt = 4'h0;
    end else if (pre_tick) begin
      pre_cnt_nxt = 4'h0;
    end else if (timer_run && osc_tick) begin
      pre_cnt_nxt = pre_cnt_r + 4'h1;
    end
  end

  // Prescaler register
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pre_cnt_r <= 4'h0;
    end else begin
      pre_cnt_r <= pre_cnt_nxt;
    end
  end

  // Postscaler counts period matches
  always_comb begin
    post_cnt_nxt = post_cnt_r;
    if (wr_count || wr_control) begin
      post_cnt_nxt = 4'h0;
    end else if (post_tick) begin
      post_cnt_nxt = 4'h0;
    end else if (match) begin
      post_cnt_nxt = post_cnt_r + 4'h1;
    end
  end

  // Postscaler register
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      post_cnt_r <= 4'h0;
    end else begin
      post_cnt_r <= post_cnt_nxt;
    end
  end

  // Timer count: a software write wins over increment and wrap
  always_comb begin
    timer_count_nxt = timer_count_r;
    if (wr_count) begin
      timer_count_nxt = WDATA;
    end else if (match) begin
      timer_count_nxt = 8'h00;
    end else if (pre_tick) begin
      timer_count_nxt = timer_count_r + 8'h01;
    end
  end

  // Control write does not touch the count
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      timer_count_r <= RST_TIMER_COUNT;
    end else begin
      timer_count_r <= timer_count_nxt;
    end
  end

  // Control register; the top bit is not implemented
  always_comb begin
    timer_control_nxt = timer_control_r;
    if (wr_control) begin
      timer_control_nxt = WDATA[6:0];
    end
  end

  // Control register storage
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      timer_control_r <= RST_TIMER_CONTROL;
    end else begin
      timer_control_r <= timer_control_nxt;
    end
  end

  // Period limit
  always_comb begin
    period_limit_nxt = period_limit_r;
    if (wr_period) begin
      period_limit_nxt = WDATA;
    end
  end

  // Period limit storage
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      period_limit_r <= RST_PERIOD_LIMIT;
    end else begin
      period_limit_r <= period_limit_nxt;
    end
  end

  // Sticky flag, write one to clear; a new event wins
  always_comb begin
    flag_nxt = flag_r;
    if (post_tick) begin
      flag_nxt = 1'b1;
    end else if (wr_status && WDATA[FLAG_BIT]) begin
      flag_nxt = 1'b0;
    end
  end

  // Flag storage
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // Interrupt enable
  always_comb begin
    mask_nxt = mask_r;
    if (wr_mask) begin
      mask_nxt = WDATA[FLAG_BIT];
    end
  end

  // Enable storage
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      mask_r <= 1'b0;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  // Match pulse, registered on the same edge that wraps the count to zero
  always_comb begin
    match_nxt = match;
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      match_r <= 1'b0;
    end else begin
      match_r <= match_nxt;
    end
  end

  // Read data for one cycle after the strobe, zero otherwise
  always_comb begin
    rdata_nxt = 8'h00;
    if (RD) begin
      unique case (ADDR)
        OFS_TIMER_COUNT: begin
          rdata_nxt = timer_count_r;
        end
        OFS_TIMER_CONTROL: begin
          rdata_nxt = {1'b0, timer_control_r};
        end
        OFS_PERIOD_LIMIT: begin
          rdata_nxt = period_limit_r;
        end
        OFS_IRQ_STATUS: begin
          rdata_nxt = flag_bits(flag_r);
        end
        OFS_IRQ_MASK: begin
          rdata_nxt = flag_bits(mask_r);
        end
        default: begin
          rdata_nxt = 8'h00;
        end
      endcase
    end
  end

  // Read data register
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= rdata_nxt;
    end
  end

  assign IRQ       = flag_r && mask_r;
  assign SSP_MATCH = match_r;
  assign PWM_MATCH = match_r;
  assign PWM_COUNT = timer_count_r;

endmodule

//--- test_period_match_timer.sv
`timescale 1ns/100ps
module test_period_match_timer;
  import pmt_pkg::*;
  logic       CORE_CLK = 0, RST_B = 0, WR = 0, RD = 0, rd_d = 0;
  logic [7:0] ADDR = 0, WDATA = 0, v, p;
  logic [3:0] n;
  wire  [7:0] RDATA, PWM_COUNT;
  wire        IRQ, SSP_MATCH, PWM_MATCH;
  logic [7:0] exp_q[$];
  int         failures = 0, comparisons = 0, i, c, t;
  pmt_timer DUT (.CORE_CLK, .RST_B, .ADDR, .WDATA, .WR, .RD, .RDATA, .IRQ, .SSP_MATCH,
    .PWM_MATCH, .PWM_COUNT);
  always #10 CORE_CLK = ~CORE_CLK;
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task final_report;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CORE_CLK);
    WR <= 1; ADDR <= a; WDATA <= d;
    @(posedge CORE_CLK);
    WR <= 0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge CORE_CLK);
    RD <= 1; ADDR <= a; exp_q.push_back(e);
    @(posedge CORE_CLK);
    RD <= 0;
  endtask
  // Read data stands in the cycle after the strobe
  always @(posedge CORE_CLK) rd_d <= RD;
  always @(negedge CORE_CLK) if (rd_d) chk("rdata", RDATA, exp_q.pop_front());
  initial begin
    void'($urandom(32'h21F11999));
    repeat (8) @(posedge CORE_CLK);
    RST_B <= 1;
    rd(OFS_TIMER_COUNT, 8'h00);
    rd(OFS_TIMER_CONTROL, 8'h00);
    rd(OFS_PERIOD_LIMIT, 8'hFF);
    rd(OFS_IRQ_STATUS, 8'h00);
    v = $urandom;
    wr(OFS_TIMER_COUNT, v);
    wr(OFS_TIMER_CONTROL, 8'hF8);
    wr(8'h33, 8'hFF);
    rd(OFS_TIMER_COUNT, v);
    rd(OFS_TIMER_CONTROL, 8'h78);
    rd(8'h33, 8'h00);
    wr(OFS_PERIOD_LIMIT, ~v);
    rd(OFS_PERIOD_LIMIT, ~v);
    wr(OFS_IRQ_MASK, 8'h02);
    for (i = 0; i < 4; i++) begin
      n = $urandom_range(15);
      p = $urandom_range(3, 1);
      wr(OFS_TIMER_CONTROL, 8'h00);
      wr(OFS_IRQ_STATUS, 8'h02);
      wr(OFS_PERIOD_LIMIT, p);
      wr(OFS_TIMER_COUNT, 8'h00);
      wr(OFS_TIMER_CONTROL, {1'b0, n, 1'b1, i[1:0]});
      // Core clocks from run to flag: product of Fosc/4 divide, period, postscale and prescale
      t = 4 * (p + 1) * (n + 1) * (i == 0 ? 1 : i == 1 ? 4 : 16);
      for (c = 0; c < t + 8 && IRQ !== 1'b1; c++) @(negedge CORE_CLK);
      chk("irq delay", {7'h00, c >= t - 6 && c <= t + 6}, 8'h01);
      if (IRQ !== 1'b1) final_report;
      chk("ssp match", {7'h00, SSP_MATCH}, 8'h01);
      chk("pwm match", {7'h00, PWM_MATCH}, 8'h01);
      chk("pwm count", PWM_COUNT, 8'h00);
      rd(OFS_IRQ_STATUS, 8'h02);
    end
    wr(OFS_TIMER_CONTROL, 8'h00);
    wr(OFS_IRQ_STATUS, 8'h02);
    rd(OFS_IRQ_STATUS, 8'h00);
    repeat (4) @(posedge CORE_CLK);
    final_report;
  end
endmodule
